// File: oaf_average_filter.v
// Operation
// - Three-bit select: 000 no averaging, 001..110 ratios 2..64, 111 invalid.
// - Set length scales with ratio; host must not start conversions faster.
// - First sample of all channels is taken on a conversion-start rising edge.
// - Remaining samples are triggered by an internal sampling strobe.
// - Each channel averages exactly ratio-count samples into one result.
// - Averaged value is decimated to one 18-bit result per channel per set.
`timescale 1ns/1ps
`include "oaf_defines.vh"

module oaf_average_filter (
  input  wire                                   sys_clk,
  input  wire                                   reset_n,
  input  wire [`OAF_SEL_W-1:0]                  average_ratio_select,
  input  wire                                   conversion_start_group_a,
  input  wire                                   conversion_start_group_b,
  input  wire                                   sample_valid,
  input  wire [`OAF_NUM_CH*`OAF_SAMPLE_W-1:0]   sample_data,
  output wire                                   sample_strobe,
  output wire                                   busy,
  output wire                                   result_valid,
  output wire                                   select_error,
  output wire [`OAF_NUM_CH*`OAF_SAMPLE_W-1:0]   result_data
);

  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_GAP  = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Ratio decode

  function [`OAF_SEL_W-1:0] ratio_shift;
    input [`OAF_SEL_W-1:0] sel;
    begin
      if (sel == `OAF_SEL_BAD) begin
        ratio_shift = `OAF_SEL_NONE;
      end else begin
        ratio_shift = sel;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Start edge detection

  reg                        start_prev_reg;
  wire                       start_level;
  wire                       start_rise;
  reg  [1:0]                 state_reg;
  reg  [1:0]                 state_next;
  reg  [`OAF_SET_W-1:0]      count_reg;
  reg  [`OAF_SET_W-1:0]      count_next;
  reg  [`OAF_SET_W-1:0]      total_reg;
  reg  [`OAF_SEL_W-1:0]      shift_reg;
  reg  [`OAF_CNT_W-1:0]      gap_reg;
  reg  [`OAF_CNT_W-1:0]      gap_next;
  reg                        strobe_next;
  wire                       last_sample;
  wire                       take;
  wire                       clear_acc;
  wire [`OAF_NUM_CH*`OAF_SAMPLE_W-1:0] avg_all;
  wire                       gap_done;
  reg  [`OAF_SET_W-1:0]      total_next;
  reg  [`OAF_SEL_W-1:0]      shift_next;
  reg                        sample_strobe_reg;
  reg                        busy_reg;
  reg                        busy_next;
  reg                        result_valid_reg;
  reg                        result_valid_next;
  reg                        select_error_reg;
  reg                        select_error_next;
  reg  [`OAF_NUM_CH*`OAF_SAMPLE_W-1:0] result_data_reg;
  reg  [`OAF_NUM_CH*`OAF_SAMPLE_W-1:0] result_data_next;

  // A start seen while busy only updates the edge history and is dropped
  assign start_level = conversion_start_group_a & conversion_start_group_b;
  assign start_rise  = start_level & ~start_prev_reg;
  assign take        = (state_reg == ST_WAIT) & sample_valid;
  assign last_sample = (count_reg + `OAF_SET_ONE == total_reg);
  assign clear_acc   = (state_reg == ST_IDLE);
  // Counted from the accepted sample, so the set length tracks the ratio
  assign gap_done    = (gap_reg >= `OAF_CONV_CYCLES);

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      start_prev_reg <= 1'b0;
    end else begin
      start_prev_reg <= start_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always @* begin
    state_next  = state_reg;
    count_next  = count_reg;
    gap_next    = gap_reg;
    strobe_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        count_next = `OAF_SET_ZERO;
        if (start_rise) begin
          strobe_next = 1'b1;
          state_next  = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (sample_valid) begin
          if (last_sample) begin
            state_next = ST_IDLE;
          end else begin
            count_next = count_reg + `OAF_SET_ONE;
            state_next = ST_GAP;
            gap_next   = {{(`OAF_CNT_W-1){1'b0}}, 1'b1};
          end
        end
      end
      ST_GAP: begin
        gap_next = gap_reg + {{(`OAF_CNT_W-1){1'b0}}, 1'b1};
        if (gap_done) begin
          strobe_next = 1'b1;
          state_next  = ST_WAIT;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ratio latch: frozen at the accepted start, so pin changes in mid-set
  // cannot alter the sample count or the decimation shift

  always @* begin
    shift_next = shift_reg;
    total_next = total_reg;
    if (state_reg == ST_IDLE && start_rise) begin
      shift_next = ratio_shift(average_ratio_select);
      total_next = `OAF_SET_ONE << ratio_shift(average_ratio_select);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output next values

  always @* begin
    busy_next         = (state_next != ST_IDLE);
    select_error_next = (average_ratio_select == `OAF_SEL_BAD);
    result_valid_next = take & last_sample;
    result_data_next  = result_data_reg;
    if (take && last_sample) begin
      result_data_next = avg_all;
    end
  end

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      state_reg         <= ST_IDLE;
      count_reg         <= `OAF_SET_ZERO;
      gap_reg           <= {`OAF_CNT_W{1'b0}};
      total_reg         <= `OAF_SET_ONE;
      shift_reg         <= `OAF_SEL_NONE;
      sample_strobe_reg <= 1'b0;
      busy_reg          <= 1'b0;
      select_error_reg  <= 1'b0;
    end else begin
      state_reg         <= state_next;
      count_reg         <= count_next;
      gap_reg           <= gap_next;
      shift_reg         <= shift_next;
      total_reg         <= total_next;
      sample_strobe_reg <= strobe_next;
      busy_reg          <= busy_next;
      select_error_reg  <= select_error_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel accumulators

  genvar ch;
  generate
    for (ch = 0; ch < `OAF_NUM_CH; ch = ch + 1) begin : g_ch
      oaf_channel_acc u_acc (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .clear   (clear_acc),
        .add_en  (take),
        .sample  (sample_data[ch*`OAF_SAMPLE_W +: `OAF_SAMPLE_W]),
        .shift   (shift_reg),
        .avg     (avg_all[ch*`OAF_SAMPLE_W +: `OAF_SAMPLE_W]),
        .sum     ()
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Result register

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      result_valid_reg <= 1'b0;
      result_data_reg  <= {(`OAF_NUM_CH*`OAF_SAMPLE_W){1'b0}};
    end else begin
      result_valid_reg <= result_valid_next;
      result_data_reg  <= result_data_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from its flip-flop

  assign sample_strobe = sample_strobe_reg;
  assign busy          = busy_reg;
  assign result_valid  = result_valid_reg;
  assign select_error  = select_error_reg;
  assign result_data   = result_data_reg;

endmodule

// File: oaf_channel_acc.v
`timescale 1ns/1ps
`include "oaf_defines.vh"

module oaf_channel_acc (
  input  wire                         sys_clk,
  input  wire                         reset_n,
  input  wire                         clear,
  input  wire                         add_en,
  input  wire [`OAF_SAMPLE_W-1:0]     sample,
  input  wire [`OAF_SEL_W-1:0]        shift,
  output wire [`OAF_SAMPLE_W-1:0]     avg,
  output wire [`OAF_ACC_W-1:0]        sum
);

  reg  [`OAF_ACC_W-1:0] acc_reg;
  wire [`OAF_ACC_W-1:0] sample_ext;
  wire [`OAF_ACC_W-1:0] shifted;

  // Sign extend the two's complement sample
  assign sample_ext = {{(`OAF_ACC_W-`OAF_SAMPLE_W){sample[`OAF_SAMPLE_W-1]}}, sample};
  assign sum        = acc_reg + sample_ext;
  // Arithmetic shift by log2(ratio) decimates back to sample width
  assign shifted    = $signed(sum) >>> shift;
  assign avg        = shifted[`OAF_SAMPLE_W-1:0];

  always @(posedge sys_clk) begin
    if (!reset_n || clear) begin
      acc_reg <= {`OAF_ACC_W{1'b0}};
    end else if (add_en) begin
      acc_reg <= sum;
    end
  end

endmodule

// File: oaf_core_model.sv
`timescale 1ns/1ps
module oaf_core_model (
  input  wire         sys_clk,
  input  wire         sample_strobe,
  input  wire [143:0] core_data,
  output reg          sample_valid,
  output reg  [143:0] sample_data
);
  reg pend_reg = 1'b0;
  initial sample_valid = 1'b0;
  initial sample_data = 144'h0;
  // Two-cycle conversion; data lines toggle outside the valid pulse
  always @(posedge sys_clk) begin
    pend_reg     <= sample_strobe;
    sample_valid <= pend_reg;
    sample_data  <= pend_reg ? core_data : ~sample_data;
  end
endmodule

// File: oaf_defines.vh
`ifndef OAF_DEFINES_VH
`define OAF_DEFINES_VH

// Sample and channel geometry
`define OAF_SAMPLE_W      18
`define OAF_NUM_CH        8
`define OAF_CH_W          3
`define OAF_ACC_W         24
`define OAF_SEL_W         3

// Set counter: wide enough for the largest ratio
`define OAF_SET_W         7
`define OAF_SET_ZERO      7'h00
`define OAF_SET_ONE       7'h01

// Ratio select codes
`define OAF_SEL_NONE      3'h0
`define OAF_SEL_MAX       3'h6
`define OAF_SEL_BAD       3'h7

// Timing: single-conversion period at 200 kSPS, clock 200 MHz
`define OAF_CONV_PERIOD_NS 5000
`define OAF_CLK_PERIOD_NS  5
`define OAF_CONV_CYCLES    (`OAF_CONV_PERIOD_NS / `OAF_CLK_PERIOD_NS)
`define OAF_CNT_W          12

`endif

// File: oaf_props.sv
`timescale 1ns/1ps
module oaf_props (
  input wire       sys_clk,
  input wire       reset_n,
  input wire [2:0] average_ratio_select,
  input wire       conversion_start_group_a,
  input wire       conversion_start_group_b,
  input wire       sample_valid,
  input wire       sample_strobe,
  input wire       busy,
  input wire       result_valid,
  input wire       select_error
);
  wire        go = conversion_start_group_a & conversion_start_group_b;
  reg  [11:0] gap_reg;
  reg         wait_reg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Cycles since the last sample, and whether a follow-up strobe is owed
  always @(posedge sys_clk) begin
    gap_reg  <= sample_valid ? 12'h0 : gap_reg + {11'h0, gap_reg != 12'hfff};
    wait_reg <= reset_n & (sample_valid | wait_reg & !sample_strobe & !result_valid);
  end
  property p_st; go && !$past(go) && !busy |=> sample_strobe; endproperty
  a_st: assert property (p_st) else $error("no strobe after start");
  property p_sp; sample_strobe |=> !sample_strobe; endproperty
  a_sp: assert property (p_sp) else $error("strobe too long");
  property p_rp; result_valid |=> !result_valid; endproperty
  a_rp: assert property (p_rp) else $error("result pulse too long");
  property p_rb; result_valid |-> !busy && !sample_strobe; endproperty
  a_rb: assert property (p_rb) else $error("result before set end");
  property p_gap; sample_strobe && wait_reg |-> gap_reg == 12'd1000; endproperty
  a_gap: assert property (p_gap) else $error("strobe spacing wrong");
  property p_gmx; wait_reg |-> gap_reg <= 12'd1000; endproperty
  a_gmx: assert property (p_gmx) else $error("strobe missing");
  property p_rv; result_valid |-> $past(sample_valid); endproperty
  a_rv: assert property (p_rv) else $error("result not after sample");
  property p_se; $past(reset_n) |-> select_error == ($past(average_ratio_select) == 3'h7);
  endproperty
  a_se: assert property (p_se) else $error("select flag wrong");
endmodule
bind oaf_average_filter oaf_props u_props (.sys_clk(sys_clk), .reset_n(reset_n),
  .average_ratio_select(average_ratio_select), .sample_valid(sample_valid),
  .conversion_start_group_a(conversion_start_group_a), .busy(busy),
  .conversion_start_group_b(conversion_start_group_b), .sample_strobe(sample_strobe),
  .result_valid(result_valid), .select_error(select_error));

// File: tb_oversampling_average_filter.sv
`timescale 1ns/1ps
module tb_oversampling_average_filter;
  reg          sys_clk   = 1'b0;
  reg          reset_n   = 1'b0;
  reg  [2:0]   sel       = 3'h0;
  reg          st        = 1'b0;
  reg  [143:0] core_data = 144'h0;
  wire         sample_valid, sample_strobe, busy, result_valid, select_error;
  wire [143:0] sample_data, result_data;
  integer      errors = 0, tests_run = 0, cyc = 0, nval, sh, code, ch, i, nres = 0;
  integer      sums [0:7];
  always #2.5 sys_clk = ~sys_clk;
  oaf_average_filter u_dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .average_ratio_select(sel), .conversion_start_group_a(st),
    .conversion_start_group_b(st), .sample_valid(sample_valid), .sample_data(sample_data),
    .sample_strobe(sample_strobe), .busy(busy), .result_valid(result_valid),
    .select_error(select_error), .result_data(result_data));
  oaf_core_model u_core (.sys_clk(sys_clk), .sample_strobe(sample_strobe),
    .core_data(core_data), .sample_valid(sample_valid), .sample_data(sample_data));
  task chk(input [17:0] got, input [17:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 99000) begin
      errors = errors + 1;
      report_and_stop;
    end
    core_data <= 144'({$urandom, $urandom, $urandom, $urandom, $urandom});
    if (sample_valid) begin
      nval = nval + 1;
      for (ch = 0; ch < 8; ch = ch + 1) sums[ch] = sums[ch] + $signed(sample_data[ch*18 +: 18]);
    end
    if (result_valid) begin
      nres = nres + 1;
      for (ch = 0; ch < 8; ch = ch + 1) chk(result_data[ch*18 +: 18], sums[ch] >>> sh);
    end
  end
  task run_set(input [2:0] c);
    begin
      @(posedge sys_clk);
      sel <= c;
      nval = 0;
      nres = 0;
      sh = (c == 3'h7) ? 0 : c;
      for (ch = 0; ch < 8; ch = ch + 1) sums[ch] = 0;
      @(posedge sys_clk);
      st <= 1'b1;
      repeat (4) @(posedge sys_clk);
      if (sh != 0) st <= 1'b0;
      @(posedge sys_clk);
      st <= 1'b1;
      i = 0;
      while (nres == 0 && i < 70000) begin
        @(posedge sys_clk);
        #1;
        i = i + 1;
      end
      chk(nval, (c == 3'h7) ? 1 : 1 << c);
      chk(select_error, c == 3'h7);
      chk(nres, 1);
      @(posedge sys_clk);
      st <= 1'b0;
    end
  endtask
  initial begin
    i = $urandom(32'hbafd);
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (code = 0; code < 5; code = code + 1) run_set(code[2:0]);
    run_set(3'h6);
    run_set(3'h7);
    report_and_stop;
  end
endmodule
